// ### rtl/pcm_pkg.sv
// Shared constants for the copper mode control block: encodings, field masks, timing.
// Assumes a single 250 MHz system clock.
package pcm_pkg;

   localparam int CLK_MHZ = 250;
   localparam int LINK_FAIL_US = 1000;
   localparam int SMOOTH_STEP_NS = 1000;
   localparam int SMOOTH_STEP_CYC = (SMOOTH_STEP_NS * CLK_MHZ + 999) / 1000;

   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;

   localparam logic [1:0] MAC_SGMII = 2'h0;
   localparam logic [1:0] MAC_QSGMII = 2'h1;

   localparam logic [1:0] MDIX_FORCE_MDI = 2'h2;
   localparam logic [1:0] MDIX_FORCE_MDIX = 2'h3;

   localparam logic [1:0] PORT_LAST = 2'h3;
   localparam logic [5:0] ADV_GIG_MASK = 6'h30;
   localparam logic [5:0] ADV_1000FD = 6'h20;
   localparam logic [5:0] ADV_1000HD = 6'h10;
   localparam logic [5:0] ADV_100FD = 6'h08;
   localparam logic [5:0] ADV_100HD = 6'h04;
   localparam logic [5:0] ADV_10FD = 6'h02;
   localparam logic [5:0] ADV_10HD = 6'h01;
   localparam logic [2:0] DS_BASE = 3'h2;
   localparam logic [3:0] BLEND_MAX = 4'hF;

   typedef enum logic [5:0] {
      ST_START = 6'h01,
      ST_FORCED = 6'h02,
      ST_ABILITY = 6'h04,
      ST_NEXTPG = 6'h08,
      ST_LINKWAIT = 6'h10,
      ST_LINKUP = 6'h20
   } pcm_state_t;

endpackage : pcm_pkg

// ### rtl/pcm_sync.sv
// Two-stage synchroniser for a bundle of slowly changing line-side levels.
// Assumes each bit is a level; multi-bit words are only read once stable.
`timescale 1ns/1ps
`default_nettype none
module pcm_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import pcm_pkg::*;

   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule : pcm_sync
`default_nettype wire

// ### rtl/pcm_pol_fix.sv
// Polarity correction state for one twisted pair.
// Assumes inv_seen is already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pcm_pol_fix (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable,
   input wire logic inv_seen,
   input wire logic link_ok,
   output logic inv_fixed
);
   import pcm_pkg::*;

   // Detection wins over the clear on link loss
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         inv_fixed <= 1'b0;
      end else if (enable && inv_seen) begin
         inv_fixed <= 1'b1;
      end else if (!enable || !link_ok) begin
         inv_fixed <= 1'b0;
      end
   end

   a_pol_fix_set: assert property (@(posedge clk_sys) disable iff (rst)
      (enable && inv_seen) |=> inv_fixed) else $error("polarity not corrected");

endmodule : pcm_pol_fix
`default_nettype wire

// ### rtl/pcm_top.sv
// Copper mode control for one PHY port: address, MAC mode, negotiation, crossover, downshift, EEE, ring timing.
// Assumes software control bits come from clk_sys logic; line-side status arrives asynchronously.
// How it works
// - Address is straps shifted left with zero appended plus port index.
// - Address-reverse bit maps port index as last minus index.
// - MAC mode 00 is SGMII, 01 QSGMII, 10 and 11 reserved.
// - Fast serial lane is QSGMII or the fourth SGMII lane by mode.
// - Negotiation runs when enable bit set, off when cleared.
// - With negotiation off, speed and duplex come from the three control bits.
// - Negotiation resolves speed, duplex, master role; next pages exchanged optionally.
// - Non-negotiating partner gets speed chosen by parallel detection.
// - No gigabit link without negotiation; forcing only covers 10 and 100.
// - Auto crossover and polarity correction on at reset; two bits disable them.
// - Crossover and polarity results are reported as status outputs.
// - With forced-crossover bit zero, crossover still runs on forced 10/100 links.
// - Four pair layouts handled: straight, crossed, each with C/D swapped.
// - Polarity inversion corrected on every pair at every speed.
// - Manual field 10 forces straight, 11 crossed, 00 leaves it automatic.
// - After set count of failed gigabit tries, advertisement drops to 100M.
// - A later gigabit-capable partner restores gigabit advertisement without reset.
// - Low power idle allowed only at 100M and 1000M.
// - Reduced-amplitude 10M mode set per port.
// - Ring slave asks reference switch, freezes recovery, locks transmit frequency.
// - Ring master moves to recovered clock smoothly, only after timing lock.
`timescale 1ns/1ps
`default_nettype none
module pcm_top #(
   parameter logic [1:0] PORT_INDEX = 2'h0,
   parameter int LINK_FAIL_CYC = pcm_pkg::LINK_FAIL_US * pcm_pkg::CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] phy_address_straps,
   input wire logic addr_reverse,
   input wire logic [1:0] mac_mode_sel,
   input wire logic soft_reset,
   input wire logic an_enable,
   input wire logic speed_sel_hi,
   input wire logic speed_sel_lo,
   input wire logic duplex_full,
   input wire logic [5:0] local_adv,
   input wire logic local_np,
   input wire logic local_pref_master,
   input wire logic mdix_auto_dis,
   input wire logic pol_corr_dis,
   input wire logic forced_mdix_dis,
   input wire logic [1:0] mdix_manual,
   input wire logic downshift_en,
   input wire logic [1:0] downshift_count,
   input wire logic eee_enable,
   input wire logic mac_tx_idle,
   input wire logic reduced_amplitude_10m_mode,
   input wire logic ring_res_enable,
   input wire logic lp_page_valid,
   input wire logic [5:0] lp_adv,
   input wire logic lp_np,
   input wire logic lp_np_done,
   input wire logic lp_pref_master,
   input wire logic [7:0] lp_seed,
   input wire logic lp_nlp_seen,
   input wire logic lp_100_idle,
   input wire logic lp_ring_capable,
   input wire logic line_link_ok,
   input wire logic pair_cross,
   input wire logic pair_cd_swap,
   input wire logic [3:0] pair_inv,
   input wire logic timing_lock,
   output logic [4:0] mgmt_addr,
   output logic mac_qsgmii,
   output logic lane_sgmii4,
   output logic mac_mode_reserved,
   output logic link_up,
   output logic [1:0] link_speed,
   output logic link_full_duplex,
   output logic is_master,
   output logic an_complete,
   output logic parallel_detected,
   output logic downshift_status,
   output logic mdix_crossed,
   output logic mdix_cd_swapped,
   output logic [3:0] polarity_fixed,
   output logic lpi_active,
   output logic tx_amp_reduced,
   output logic ref_switch_req,
   output logic timing_freeze,
   output logic tx_freq_lock,
   output logic [3:0] tx_clk_blend,
   output logic tx_clk_recovered
);
   import pcm_pkg::*;

   localparam int SW = 29;
   localparam int FW = $clog2(LINK_FAIL_CYC + 1);
   localparam int BW = $clog2(SMOOTH_STEP_CYC + 1);

   // Checks skip the releasing edge, whose samples still hold reset values
   logic armed_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else begin
         armed_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || !armed_reg);

   logic [3:0] straps_s;
   logic lp_page_s, lp_np_s, lp_np_done_s, lp_pm_s, lp_nlp_s, lp_idle_s, lp_ring_s;
   logic link_ok_s, cross_s, cd_s, lock_s;
   logic [5:0] lp_adv_s;
   logic [7:0] lp_seed_s;
   logic [3:0] inv_s;

   // Line-side levels are asynchronous
   pcm_sync #(.W(SW)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d({phy_address_straps, lp_page_valid, lp_adv, lp_np, lp_np_done, lp_pref_master, lp_seed,
          lp_nlp_seen, lp_100_idle, lp_ring_capable, line_link_ok, pair_cross, pair_cd_swap, timing_lock}),
      .q({straps_s, lp_page_s, lp_adv_s, lp_np_s, lp_np_done_s, lp_pm_s, lp_seed_s,
          lp_nlp_s, lp_idle_s, lp_ring_s, link_ok_s, cross_s, cd_s, lock_s})
   );

   pcm_sync #(.W(4)) u_sync_inv (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(pair_inv),
      .q(inv_s)
   );

   // Mode settings are applied at reset release and on each soft reset
   logic cfg_load_reg;
   logic an_en_act_reg;
   logic [1:0] frc_spd_act_reg;
   logic frc_fd_act_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_load_reg <= 1'b1;
      end else begin
         cfg_load_reg <= soft_reset;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         an_en_act_reg <= 1'b1;
         frc_spd_act_reg <= SPD_10;
         frc_fd_act_reg <= 1'b0;
         mac_qsgmii <= 1'b0;
         lane_sgmii4 <= 1'b0;
         mac_mode_reserved <= 1'b0;
      end else if (cfg_load_reg) begin
         an_en_act_reg <= an_enable;
         frc_spd_act_reg <= {speed_sel_hi, speed_sel_lo};
         frc_fd_act_reg <= duplex_full;
         mac_qsgmii <= (mac_mode_sel == MAC_QSGMII);
         lane_sgmii4 <= (mac_mode_sel == MAC_SGMII);
         mac_mode_reserved <= mac_mode_sel[1];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mgmt_addr <= 5'h00;
      end else begin
         mgmt_addr <= {straps_s, 1'b0} + {3'h0, addr_reverse ? PORT_LAST - PORT_INDEX : PORT_INDEX};
      end
   end

   // Highest common denominator: {found, speed, full duplex}
   function automatic logic [3:0] hcd(input logic [5:0] c);
      if (|(c & ADV_1000FD)) hcd = {1'b1, SPD_1000, 1'b1};
      else if (|(c & ADV_1000HD)) hcd = {1'b1, SPD_1000, 1'b0};
      else if (|(c & ADV_100FD)) hcd = {1'b1, SPD_100, 1'b1};
      else if (|(c & ADV_100HD)) hcd = {1'b1, SPD_100, 1'b0};
      else if (|(c & ADV_10FD)) hcd = {1'b1, SPD_10, 1'b1};
      else if (|(c & ADV_10HD)) hcd = {1'b1, SPD_10, 1'b0};
      else hcd = 4'h0;
   endfunction : hcd

   pcm_state_t st_reg;
   logic [FW-1:0] fail_cnt_reg;
   logic [2:0] attempts_reg;
   logic [7:0] seed_reg;
   logic gig_back;
   logic [5:0] adv_eff;
   logic [3:0] res;
   logic frc_ok;

   // A silent line marks a new partner; the same partner must not undo a downshift
   logic lp_gone_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lp_gone_reg <= 1'b0;
      end else if (!lp_page_s && !lp_idle_s && !lp_nlp_s) begin
         lp_gone_reg <= 1'b1;
      end else if (!downshift_status) begin
         lp_gone_reg <= 1'b0;
      end
   end

   assign gig_back = lp_gone_reg && |(lp_adv_s & ADV_GIG_MASK);
   assign adv_eff = (downshift_status && !gig_back) ? (local_adv & ~ADV_GIG_MASK) : local_adv;
   assign res = hcd(adv_eff & lp_adv_s);
   assign frc_ok = (frc_spd_act_reg == SPD_10) || (frc_spd_act_reg == SPD_100);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seed_reg <= 8'h00;
      end else begin
         seed_reg <= seed_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= ST_START;
         fail_cnt_reg <= '0;
         attempts_reg <= 3'h0;
         link_speed <= SPD_10;
         link_full_duplex <= 1'b0;
         is_master <= 1'b0;
         an_complete <= 1'b0;
         parallel_detected <= 1'b0;
         downshift_status <= 1'b0;
      end else if (cfg_load_reg) begin
         st_reg <= ST_START;
         an_complete <= 1'b0;
      end else begin
         case (st_reg)
            ST_START: begin
               st_reg <= an_en_act_reg ? ST_ABILITY : ST_FORCED;
            end
            ST_FORCED: begin
               link_speed <= frc_spd_act_reg;
               link_full_duplex <= frc_fd_act_reg;
               parallel_detected <= 1'b0;
               if (link_ok_s && frc_ok) begin
                  st_reg <= ST_LINKUP;
               end
            end
            ST_ABILITY: begin
               an_complete <= 1'b0;
               fail_cnt_reg <= '0;
               if (lp_page_s && res[3]) begin
                  link_speed <= res[2:1];
                  link_full_duplex <= res[0];
                  parallel_detected <= 1'b0;
                  if (local_pref_master != lp_pm_s) begin
                     is_master <= local_pref_master;
                  end else begin
                     is_master <= (seed_reg > lp_seed_s);
                  end
                  if (gig_back) begin
                     downshift_status <= 1'b0;
                  end
                  st_reg <= (local_np && lp_np_s) ? ST_NEXTPG : ST_LINKWAIT;
               end else if (!lp_page_s && lp_idle_s) begin
                  link_speed <= SPD_100;
                  link_full_duplex <= 1'b0;
                  parallel_detected <= 1'b1;
                  st_reg <= ST_LINKWAIT;
               end else if (!lp_page_s && lp_nlp_s) begin
                  link_speed <= SPD_10;
                  link_full_duplex <= 1'b0;
                  parallel_detected <= 1'b1;
                  st_reg <= ST_LINKWAIT;
               end
            end
            ST_NEXTPG: begin
               if (lp_np_done_s) begin
                  st_reg <= ST_LINKWAIT;
               end
            end
            ST_LINKWAIT: begin
               an_complete <= 1'b1;
               if (link_ok_s) begin
                  attempts_reg <= 3'h0;
                  st_reg <= ST_LINKUP;
               end else if (fail_cnt_reg == FW'(LINK_FAIL_CYC - 1)) begin
                  fail_cnt_reg <= '0;
                  st_reg <= ST_ABILITY;
                  if (link_speed == SPD_1000) begin
                     // Count failed gigabit tries only
                     if (downshift_en && (attempts_reg + 3'h1 >= DS_BASE + {1'b0, downshift_count})) begin
                        downshift_status <= 1'b1;
                        attempts_reg <= 3'h0;
                     end else begin
                        attempts_reg <= attempts_reg + 3'h1;
                     end
                  end
               end else begin
                  fail_cnt_reg <= fail_cnt_reg + FW'(1);
               end
            end
            ST_LINKUP: begin
               if (!link_ok_s) begin
                  st_reg <= an_en_act_reg ? ST_ABILITY : ST_FORCED;
               end
            end
            default: begin
               st_reg <= ST_START;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         link_up <= 1'b0;
      end else begin
         link_up <= (st_reg == ST_LINKUP) && link_ok_s;
      end
   end

   // Crossover result held while linked to avoid flipping pairs mid-frame
   logic auto_ok;
   assign auto_ok = !mdix_auto_dis && (an_en_act_reg || !forced_mdix_dis);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mdix_crossed <= 1'b0;
         mdix_cd_swapped <= 1'b0;
      end else begin
         case (mdix_manual)
            MDIX_FORCE_MDI: begin
               mdix_crossed <= 1'b0;
               mdix_cd_swapped <= 1'b0;
            end
            MDIX_FORCE_MDIX: begin
               mdix_crossed <= 1'b1;
               mdix_cd_swapped <= 1'b0;
            end
            default: begin
               if (!auto_ok) begin
                  mdix_crossed <= 1'b0;
                  mdix_cd_swapped <= 1'b0;
               end else if (!link_up) begin
                  mdix_crossed <= cross_s;
                  mdix_cd_swapped <= cd_s;
               end
            end
         endcase
      end
   end

   // Polarity on every pair, independent of speed
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pol
         pcm_pol_fix u_pol (
            .clk_sys(clk_sys),
            .rst(rst),
            .enable(!pol_corr_dis),
            .inv_seen(inv_s[gi]),
            .link_ok(link_ok_s),
            .inv_fixed(polarity_fixed[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lpi_active <= 1'b0;
         tx_amp_reduced <= 1'b0;
      end else begin
         lpi_active <= eee_enable && link_up && mac_tx_idle && (link_speed != SPD_10);
         tx_amp_reduced <= reduced_amplitude_10m_mode && (link_speed == SPD_10);
      end
   end

   // Ring timing handover; needs a capable partner
   logic ring_gig;
   logic [BW-1:0] step_cnt_reg;
   assign ring_gig = ring_res_enable && lp_ring_s && link_up && (link_speed == SPD_1000);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_switch_req <= 1'b0;
         timing_freeze <= 1'b0;
         tx_freq_lock <= 1'b0;
      end else begin
         ref_switch_req <= ring_gig && !is_master;
         timing_freeze <= ring_gig && !is_master;
         tx_freq_lock <= ring_gig && !is_master;
      end
   end

   // Blend ramps up one step per interval; it returns to zero at once when ring_gig, is_master or lock_s drops
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         step_cnt_reg <= '0;
         tx_clk_blend <= 4'h0;
         tx_clk_recovered <= 1'b0;
      end else if (!(ring_gig && is_master && lock_s)) begin
         step_cnt_reg <= '0;
         tx_clk_blend <= 4'h0;
         tx_clk_recovered <= 1'b0;
      end else if (tx_clk_blend != BLEND_MAX) begin
         if (step_cnt_reg == BW'(SMOOTH_STEP_CYC - 1)) begin
            step_cnt_reg <= '0;
            tx_clk_blend <= tx_clk_blend + 4'h1;
         end else begin
            step_cnt_reg <= step_cnt_reg + BW'(1);
         end
      end else begin
         tx_clk_recovered <= 1'b1;
      end
   end

   a_addr_map: assert property ($stable(straps_s) && $stable(addr_reverse) |=>
      mgmt_addr == {$past(straps_s), 1'b0} + {3'h0, $past(addr_reverse) ? PORT_LAST - PORT_INDEX : PORT_INDEX})
      else $error("address map wrong");
   a_mac_mode_decode: assert property (cfg_load_reg |=>
      (mac_qsgmii == ($past(mac_mode_sel) == MAC_QSGMII)) && (lane_sgmii4 == ($past(mac_mode_sel) == MAC_SGMII)))
      else $error("mac mode decode wrong");
   a_forced_speed: assert property ((st_reg == ST_FORCED) && !cfg_load_reg |=>
      link_speed == $past(frc_spd_act_reg) && link_full_duplex == $past(frc_fd_act_reg))
      else $error("forced speed not applied");
   a_no_forced_gig: assert property (link_up && !an_en_act_reg |-> link_speed != SPD_1000)
      else $error("gigabit link without negotiation");
   a_manual_mdi: assert property (mdix_manual == MDIX_FORCE_MDI |=> !mdix_crossed)
      else $error("manual straight ignored");
   a_lpi_speed: assert property (lpi_active |-> $past(link_speed) != SPD_10 && $past(link_up))
      else $error("idle signaling at wrong speed");
   a_amp_10m: assert property (tx_amp_reduced |-> $past(link_speed) == SPD_10 && $past(reduced_amplitude_10m_mode))
      else $error("reduced amplitude off 10M");
   a_slave_freeze: assert property (ring_gig && !is_master |=> timing_freeze && tx_freq_lock && ref_switch_req)
      else $error("ring slave did not freeze");
   a_master_lock: assert property (tx_clk_blend != 4'h0 |-> $past(lock_s) && is_master)
      else $error("clock moved before lock");

endmodule : pcm_top
`default_nettype wire

// ### testbench/pcm_lp_model.sv
// Copper link partner: pages, idle or pulse signalling, pair wiring, ring lock.
// Assumes the bench picks its mode; outputs are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module pcm_lp_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [1:0] mode_cfg,
   input wire logic [5:0] adv_cfg,
   input wire logic master_cfg,
   input wire logic cross_cfg,
   input wire logic swap_cfg,
   input wire logic [3:0] inv_cfg,
   input wire logic ring_cfg,
   input wire logic link_cfg,
   output logic lp_page_valid,
   output logic [5:0] lp_adv,
   output logic lp_np,
   output logic lp_np_done,
   output logic lp_pref_master,
   output logic [7:0] lp_seed,
   output logic lp_nlp_seen,
   output logic lp_100_idle,
   output logic lp_ring_capable,
   output logic line_link_ok,
   output logic pair_cross,
   output logic pair_cd_swap,
   output logic [3:0] pair_inv,
   output logic timing_lock
);
   logic [6:0] lock_cnt_reg;
   // Mode 1 pages, 2 sends 100M idle, 3 sends link pulses, 0 silent
   assign lp_page_valid = (mode_cfg == 2'h1);
   // Outside pages the lines are not held: show the inverse, never a stale copy
   assign lp_adv = lp_page_valid ? adv_cfg : ~adv_cfg;
   assign lp_np = 1'b0;
   assign lp_np_done = 1'b0;
   assign lp_pref_master = master_cfg;
   assign lp_seed = 8'h80;
   assign lp_100_idle = (mode_cfg == 2'h2);
   assign lp_nlp_seen = (mode_cfg == 2'h3);
   assign lp_ring_capable = ring_cfg;
   assign line_link_ok = link_cfg;
   assign pair_cross = cross_cfg;
   assign pair_cd_swap = swap_cfg;
   assign pair_inv = inv_cfg;
   assign timing_lock = lock_cnt_reg[6];
   // Lock comes a while after the ring link forms
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_cnt_reg <= 7'h00;
      end else if (!(ring_cfg && link_cfg)) begin
         lock_cnt_reg <= 7'h00;
      end else if (!lock_cnt_reg[6]) begin
         lock_cnt_reg <= lock_cnt_reg + 7'h01;
      end
   end
endmodule : pcm_lp_model
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for pcm_top with a copper partner model.
// Assumes the design's own assertions run alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pcm_pkg::*;
   localparam logic [1:0] IDX = 2'h1;
   logic clk_sys, rst, addr_reverse, soft_reset, an_enable, speed_sel_hi, speed_sel_lo, duplex_full, local_np;
   logic local_pref_master, mdix_auto_dis, pol_corr_dis, forced_mdix_dis, downshift_en, eee_enable, mac_tx_idle;
   logic reduced_amplitude_10m_mode, ring_res_enable, master_cfg, cross_cfg, swap_cfg, ring_cfg, link_cfg;
   logic [3:0] phy_address_straps, inv_cfg, polarity_fixed, tx_clk_blend;
   logic [1:0] mac_mode_sel, mdix_manual, downshift_count, mode_cfg, link_speed;
   logic [5:0] local_adv, adv_cfg;
   logic [4:0] mgmt_addr;
   wire logic lp_page_valid, lp_np, lp_np_done, lp_pref_master, lp_nlp_seen, lp_100_idle, lp_ring_capable;
   wire logic line_link_ok, pair_cross, pair_cd_swap, timing_lock;
   wire logic [5:0] lp_adv;
   wire logic [7:0] lp_seed;
   wire logic [3:0] pair_inv;
   logic mac_qsgmii, lane_sgmii4, mac_mode_reserved, link_up, link_full_duplex, is_master, an_complete;
   logic parallel_detected, downshift_status, mdix_crossed, mdix_cd_swapped, lpi_active, tx_amp_reduced;
   logic ref_switch_req, timing_freeze, tx_freq_lock, tx_clk_recovered;
   int bad_count, total_checks;
   logic [1:0] sp [3] = '{SPD_100, SPD_10, SPD_1000};

   // Short fail timer keeps negotiation retries quick
   pcm_top #(.PORT_INDEX(IDX), .LINK_FAIL_CYC(20)) i_dut (.*);
   pcm_lp_model i_lp (.*);

   always #2 clk_sys = ~clk_sys;

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic sr;
      soft_reset <= 1'b1;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      wt(4);
   endtask : sr

   // Link dropped first: crossover is only sampled while down
   task automatic relink(input logic up);
      int i;
      @(posedge clk_sys);
      link_cfg <= 1'b0;
      wt(6);
      sr();
      link_cfg <= 1'b1;
      for (i = 0; i < 300 && link_up !== up; i++) @(posedge clk_sys);
      wt(up ? 6 : 100);
      chk("link_up", link_up, up);
   endtask : relink

   task automatic t_addr;
      phy_address_straps <= 4'hA;
      wt(5);
      chk("mgmt_addr", mgmt_addr, {4'hA, 1'b0} + IDX);
      addr_reverse <= 1'b1;
      wt(5);
      chk("mgmt_addr_rev", mgmt_addr, {4'hA, 1'b0} + (PORT_LAST - IDX));
   endtask : t_addr

   task automatic t_mac;
      for (int m = 0; m < 4; m++) begin
         mac_mode_sel <= m[1:0];
         @(posedge clk_sys);
         sr();
         chk("mac_qsgmii", mac_qsgmii, m[1:0] == MAC_QSGMII);
         chk("lane_sgmii4", lane_sgmii4, m[1:0] == MAC_SGMII);
         chk("mac_reserved", mac_mode_reserved, m[1]);
      end
   endtask : t_mac

   task automatic t_forced;
      an_enable <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         {speed_sel_hi, speed_sel_lo} <= sp[i];
         duplex_full <= ~i[0];
         relink(sp[i] != SPD_1000);
         if (sp[i] != SPD_1000) begin
            chk("speed", link_speed, sp[i]);
            chk("duplex", link_full_duplex, !i[0]);
            chk("an_complete", an_complete, 1'b0);
            chk("lpi", lpi_active, sp[i] != SPD_10);
            chk("amp", tx_amp_reduced, sp[i] == SPD_10);
         end
      end
   endtask : t_forced

   task automatic t_an;
      an_enable <= 1'b1;
      {master_cfg, mode_cfg} <= 3'h5;
      relink(1'b1);
      chk("an_speed", link_speed, SPD_1000);
      chk("an_duplex", link_full_duplex, 1'b1);
      chk("an_master", is_master, 1'b0);
      chk("an_complete", an_complete, 1'b1);
      for (int i = 2; i < 4; i++) begin
         mode_cfg <= i[1:0];
         relink(1'b1);
         chk("pd_speed", link_speed, i == 2 ? SPD_100 : SPD_10);
         chk("pd_flag", parallel_detected, 1'b1);
      end
   endtask : t_an

   task automatic t_mdix;
      an_enable <= 1'b0;
      {speed_sel_hi, speed_sel_lo} <= SPD_100;
      inv_cfg <= 4'h5;
      for (int i = 0; i < 4; i++) begin
         {cross_cfg, swap_cfg} <= i[1:0];
         relink(1'b1);
         chk("crossed", mdix_crossed, i[1]);
         chk("cd_swapped", mdix_cd_swapped, i[0]);
         chk("pol", polarity_fixed, 4'h5);
      end
      mdix_manual <= MDIX_FORCE_MDI;
      relink(1'b1);
      chk("man_mdi", mdix_crossed, 1'b0);
      mdix_manual <= MDIX_FORCE_MDIX;
      cross_cfg <= 1'b0;
      relink(1'b1);
      chk("man_mdix", mdix_crossed, 1'b1);
      {mdix_manual, mdix_auto_dis, pol_corr_dis, cross_cfg} <= 5'h07;
      relink(1'b1);
      chk("auto_off", mdix_crossed, 1'b0);
      chk("pol_off", polarity_fixed, 4'h0);
      {mdix_auto_dis, forced_mdix_dis} <= 2'h1;
      relink(1'b1);
      chk("frc_mdix_off", mdix_crossed, 1'b0);
   endtask : t_mdix

   task automatic t_ring;
      {an_enable, ring_res_enable, ring_cfg, local_pref_master, master_cfg, mode_cfg} <= 7'h79;
      relink(1'b1);
      chk("master", is_master, 1'b1);
      for (int i = 0; i < 5000 && tx_clk_recovered !== 1'b1; i++) @(posedge clk_sys);
      chk("recovered", tx_clk_recovered, 1'b1);
      chk("blend", tx_clk_blend, BLEND_MAX);
      chk("m_ref", ref_switch_req, 1'b0);
      {local_pref_master, master_cfg} <= 2'h1;
      relink(1'b1);
      chk("slave", {ref_switch_req, timing_freeze, tx_freq_lock, tx_clk_recovered}, 4'hE);
   endtask : t_ring

   // Line kept dead: two failed gigabit tries, then a silent line and a new partner
   task automatic t_down;
      {downshift_en, link_cfg} <= 2'h2;
      wt(6);
      sr();
      wt(120);
      chk("downshift", downshift_status, 1'b1);
      chk("ds_speed", link_speed, SPD_100);
      mode_cfg <= 2'h0;
      wt(8);
      mode_cfg <= 2'h1;
      wt(30);
      chk("ds_lifted", downshift_status, 1'b0);
      chk("ds_gig", link_speed, SPD_1000);
   endtask : t_down

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   initial begin
      {clk_sys, addr_reverse, soft_reset, speed_sel_hi, speed_sel_lo, duplex_full, local_np, local_pref_master,
       mdix_auto_dis, pol_corr_dis, forced_mdix_dis, downshift_en, master_cfg, cross_cfg, swap_cfg, ring_cfg,
       link_cfg, ring_res_enable, phy_address_straps, inv_cfg, mac_mode_sel, mdix_manual, downshift_count} = '0;
      {rst, an_enable, eee_enable, mac_tx_idle, reduced_amplitude_10m_mode, local_adv} = 11'h7FF;
      {mode_cfg, adv_cfg, bad_count, total_checks} = {2'h0, ADV_1000FD | ADV_100FD, 64'h0};
      wt(10);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_addr();
      t_mac();
      t_forced();
      t_an();
      t_mdix();
      t_ring();
      t_down();
      wrap_up();
   end

   // Far beyond the roughly 4500 cycles the tests need
   initial begin
      wt(40000);
      bad_count++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
